// ==== rtl/lpsr_defs.vh ====
// Command codes, field layouts and reset values of the load status block.
`ifndef LPSR_DEFS_VH
`define LPSR_DEFS_VH

// ==========================================================
// Command codes
`define LPSR_HV_LIM_SET   5'h00
`define LPSR_HV_LIM_QRY   5'h01
`define LPSR_HV_ERR_SET   5'h02
`define LPSR_HV_ERR_QRY   5'h03
`define LPSR_LV_LIM_SET   5'h04
`define LPSR_LV_LIM_QRY   5'h05
`define LPSR_LV_ERR_SET   5'h06
`define LPSR_LV_ERR_QRY   5'h07
`define LPSR_PULSE_CFG    5'h08
`define LPSR_PULSE_QRY    5'h09
`define LPSR_PULSE_START  5'h0a
`define LPSR_CH_EVT_QRY   5'h0b
`define LPSR_CH_COND_SET  5'h0c
`define LPSR_CH_COND_QRY  5'h0d
`define LPSR_CH_MASK_SET  5'h0e
`define LPSR_CH_MASK_QRY  5'h0f
`define LPSR_SUM_EVT_QRY  5'h10
`define LPSR_SUM_MASK_SET 5'h11
`define LPSR_SUM_MASK_QRY 5'h12
`define LPSR_OP_EVT_QRY   5'h13
`define LPSR_OP_MASK_SET  5'h14
`define LPSR_OP_MASK_QRY  5'h15

// ==========================================================
// Channel register bits
`define LPSR_CH_VFAULT    0
`define LPSR_CH_OCURR     1
`define LPSR_CH_OPOWER    3
`define LPSR_CH_OTEMP     4
`define LPSR_CH_OVOLT     12
`define LPSR_CH_SHUTDOWN  13
`define LPSR_CH_USED      16'h301b
`define LPSR_SUM_USED     16'h7fff

// ==========================================================
// Pulse query field selects and limits
`define LPSR_PQ_LEVEL     2'h0
`define LPSR_PQ_TIME      2'h1
`define LPSR_PQ_COUNT     2'h2
`define LPSR_PQ_PERIOD    2'h3
`define LPSR_COUNT_RST    16'h0001
`define LPSR_COUNT_MAX    16'hfde8
`define LPSR_ZERO16       16'h0000

`endif

// ==== rtl/lpsr_top.v ====
// Protection limits and status registers of a programmable load.
`timescale 1ns/1ns
// Notes on behaviour
// - High-voltage limit is kept in non-volatile store and reloaded at power-up.
// - High-voltage error set command with argument 0 clears the error flag.
// - High-voltage error query answers 1 after a trip since clear, else 0.
// - Low-voltage limit is kept in non-volatile store and restored at power-up.
// - Low-voltage flag sets when input drops below limit; only write 0 clears.
// - Low-voltage error query answers 1 after an error, else 0.
// - Repeat count is optional, defaults to 1, accepted up to 65000.
// - Pulse configuration only stores; a separate start command launches it.
// - Pulse query returns level, duration, count and period when set.
// - Each power module has 16-bit condition, event and mask registers.
// - Channel bits: 0,1,3,4,12,13 used; 2, 5-11, 14, 15 unused.
// - Condition bits follow module state directly, never latched.
// - Event bits set on condition and hold until explicit clear.
// - Channel condition command with argument 0 clears event bits.
// - The same command also zeroes the channel mask register.
// - Channel mask gates which latched events reach summary indicators.
// - Summary bit 0 master, bits 1-14 followers, bit 15 unused.
// - Summary mask selects module bits setting summary event; readable.
// - Operation event register latches events; any read clears it.
// - Operation summary is OR of masked operation event bits.
`include "lpsr_defs.vh"

module lpsr_top #(
  parameter VW    = 16,  // Width of voltage values.
  parameter N_MOD = 15   // Master plus fourteen followers.
) (
  input  wire               clk_in,           // 50 MHz clock.
  input  wire               srst_in,          // Synchronous reset, high.
  input  wire               ce_in,            // Clock enable, freezes state when low.
  input  wire               cmd_valid_in,     // Command strobe, one cycle.
  input  wire [4:0]         cmd_code_in,      // Command code.
  input  wire [3:0]         cmd_mod_in,       // Power module index.
  input  wire [15:0]        cmd_arg_in,       // Value or level argument.
  input  wire [15:0]        cmd_time_in,      // Pulse duration argument.
  input  wire [15:0]        cmd_period_in,    // Pulse period argument.
  input  wire [15:0]        cmd_count_in,     // Pulse repeat count argument.
  input  wire               cmd_has_per_in,   // Period supplied.
  input  wire               cmd_has_cnt_in,   // Count supplied.
  input  wire [VW-1:0]      nv_hv_lim_in,     // Stored high limit from NV memory.
  input  wire [VW-1:0]      nv_lv_lim_in,     // Stored low limit from NV memory.
  input  wire [VW-1:0]      meas_v_in,        // Measured input voltage.
  input  wire               meas_ok_in,       // Measurement valid.
  input  wire [N_MOD*16-1:0] mod_cond_in,     // Live module conditions.
  input  wire [15:0]        op_evt_in,        // Operation event pulses.
  output reg                rsp_valid_out,    // Answer strobe.
  output reg  [15:0]        rsp_data_out,     // Answer value.
  output reg                rsp_err_out,      // Command refused.
  output reg                rsp_has_per_out,  // Period stored, with pulse query.
  output reg                nv_wr_out,        // NV write strobe.
  output reg                nv_sel_out,       // 0 high limit, 1 low limit.
  output reg  [VW-1:0]      nv_data_out,      // NV write data.
  output reg  [VW-1:0]      hv_lim_out,       // High-voltage limit.
  output reg  [VW-1:0]      lv_lim_out,       // Low-voltage limit.
  output reg                hv_err_out,       // High-voltage error flag.
  output reg                lv_err_out,       // Low-voltage error flag.
  output reg                pulse_start_out,  // Launch pulse train.
  output reg                op_summary_out,   // Status byte bit 7.
  output reg  [15:0]        sum_event_out     // Module summary event.
);

  // ==========================================================
  // Command decode
  // A command is taken only on an enabled edge; everything below keys off go.
  // Clearing commands accept nothing but a zero argument.
  wire       go     = ce_in & cmd_valid_in;
  wire       arg0   = (cmd_arg_in == `LPSR_ZERO16);
  wire       mod_ok = ({28'h0000000, cmd_mod_in} < N_MOD);
  wire       is_hv_clr  = go & (cmd_code_in == `LPSR_HV_ERR_SET) & arg0;
  wire       is_lv_clr  = go & (cmd_code_in == `LPSR_LV_ERR_SET) & arg0;
  wire       is_ch_clr  = go & (cmd_code_in == `LPSR_CH_COND_SET) & arg0 & mod_ok;
  wire       is_ch_mask = go & (cmd_code_in == `LPSR_CH_MASK_SET) & mod_ok;
  wire       is_op_rd   = go & (cmd_code_in == `LPSR_OP_EVT_QRY);

  // ==========================================================
  // Per-module channel registers
  // One condition, event and mask word per module, master first.
  // The masked OR of each module feeds one bit of the module summary.
  reg  [15:0] ch_evt_q  [0:N_MOD-1];
  reg  [15:0] ch_mask_q [0:N_MOD-1];
  wire [15:0] ch_cond   [0:N_MOD-1];
  wire [N_MOD-1:0] mod_hit;

  genvar g;
  generate
    for (g = 0; g < N_MOD; g = g + 1) begin : g_mod
      // Module select compares at full width, as a genvar has no part-select.
      wire sel = ({28'h0000000, cmd_mod_in} == g);
      // Condition bits are wired straight through; unused bits forced low.
      assign ch_cond[g] = mod_cond_in[g*16 +: 16] & `LPSR_CH_USED;
      // Masked latched events feed the module summary.
      assign mod_hit[g] = |(ch_evt_q[g] & ch_mask_q[g]);
      // New conditions are merged after the clear so a same-cycle event survives.
      always @(posedge clk_in) begin
        if (srst_in) begin
          ch_evt_q[g]  <= 16'h0000;
          ch_mask_q[g] <= 16'h0000;
        end else if (ce_in) begin
          ch_evt_q[g] <= ((is_ch_clr && sel) ? 16'h0000 : ch_evt_q[g])
                         | ch_cond[g];
          if (is_ch_clr && sel) begin
            ch_mask_q[g] <= 16'h0000;
          end else if (is_ch_mask && sel) begin
            ch_mask_q[g] <= cmd_arg_in & `LPSR_CH_USED;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // State registers
  // Mask, operation event and pulse parameter storage.
  // The stored period reads back as zero when none was supplied.
  reg [15:0] sum_mask_q;
  reg [15:0] op_evt_q;
  reg [15:0] op_mask_q;
  reg [15:0] p_level_q;
  reg [15:0] p_time_q;
  reg [15:0] p_period_q;
  reg [15:0] p_count_q;
  reg        p_has_per_q;

  // Next-state terms shared by the registers below.
  wire [15:0] sum_raw = {{(16 - N_MOD){1'b0}}, mod_hit};
  wire        cnt_bad = cmd_has_cnt_in &
                        ((cmd_count_in > `LPSR_COUNT_MAX) | (cmd_count_in == 16'h0000));
  wire [15:0] op_evt_d = (is_op_rd ? 16'h0000 : op_evt_q) | op_evt_in;
  wire        hv_trip  = meas_ok_in & (meas_v_in > hv_lim_out);
  wire        lv_trip  = meas_ok_in & (meas_v_in < lv_lim_out);

  // Limits reload from NV on reset, so a power-up restores the last setting.
  // The NV write is one strobe per limit command; the store itself sits outside.
  // A limit is not range-checked, so the host owns its plausibility.
  always @(posedge clk_in) begin
    if (srst_in) begin
      hv_lim_out  <= nv_hv_lim_in;
      lv_lim_out  <= nv_lv_lim_in;
      nv_wr_out   <= 1'b0;
      nv_sel_out  <= 1'b0;
      nv_data_out <= {VW{1'b0}};
    end else if (ce_in) begin
      nv_wr_out <= 1'b0;
      if (go && cmd_code_in == `LPSR_HV_LIM_SET) begin
        hv_lim_out  <= cmd_arg_in[VW-1:0];
        nv_wr_out   <= 1'b1;
        nv_sel_out  <= 1'b0;
        nv_data_out <= cmd_arg_in[VW-1:0];
      end else if (go && cmd_code_in == `LPSR_LV_LIM_SET) begin
        lv_lim_out  <= cmd_arg_in[VW-1:0];
        nv_wr_out   <= 1'b1;
        nv_sel_out  <= 1'b1;
        nv_data_out <= cmd_arg_in[VW-1:0];
      end
    end
  end

  // Error flags: a trip in the clearing cycle wins over the clear.
  // The comparison uses the limit in force, so a new limit acts from the next cycle.
  // Set wins over clear, so a fault present during the clear is never lost.
  always @(posedge clk_in) begin
    if (srst_in) begin
      hv_err_out <= 1'b0;
      lv_err_out <= 1'b0;
    end else if (ce_in) begin
      hv_err_out <= hv_trip | (hv_err_out & ~is_hv_clr);
      lv_err_out <= lv_trip | (lv_err_out & ~is_lv_clr);
    end
  end

  // Pulse parameters are only stored here; launching needs its own command.
  // A refused count leaves every stored field as it was.
  // The launch strobe is one cycle wide and carries no parameters.
  // Duration and period are stored raw; the host keeps them legal.
  always @(posedge clk_in) begin
    if (srst_in) begin
      p_level_q       <= 16'h0000;
      p_time_q        <= 16'h0000;
      p_period_q      <= 16'h0000;
      p_count_q       <= `LPSR_COUNT_RST;
      p_has_per_q     <= 1'b0;
      pulse_start_out <= 1'b0;
    end else if (ce_in) begin
      pulse_start_out <= go & (cmd_code_in == `LPSR_PULSE_START);
      if (go && cmd_code_in == `LPSR_PULSE_CFG && !cnt_bad) begin
        p_level_q   <= cmd_arg_in;
        p_time_q    <= cmd_time_in;
        p_period_q  <= cmd_has_per_in ? cmd_period_in : 16'h0000;
        p_has_per_q <= cmd_has_per_in;
        p_count_q   <= cmd_has_cnt_in ? cmd_count_in : `LPSR_COUNT_RST;
      end
    end
  end

  // Summary, mask and operation registers.
  // The module summary is not sticky; the channel events already latch.
  // Mask writes drop the unused top summary bit.
  always @(posedge clk_in) begin
    if (srst_in) begin
      sum_mask_q     <= 16'h0000;
      op_evt_q       <= 16'h0000;
      op_mask_q      <= 16'h0000;
      sum_event_out  <= 16'h0000;
      op_summary_out <= 1'b0;
    end else if (ce_in) begin
      if (go && cmd_code_in == `LPSR_SUM_MASK_SET) begin
        sum_mask_q <= cmd_arg_in & `LPSR_SUM_USED;
      end
      if (go && cmd_code_in == `LPSR_OP_MASK_SET) begin
        op_mask_q <= cmd_arg_in;
      end
      // Read clears, but an event arriving in the read cycle is kept.
      op_evt_q       <= op_evt_d;
      sum_event_out  <= sum_raw & sum_mask_q & `LPSR_SUM_USED;
      op_summary_out <= |(op_evt_d & op_mask_q);
    end
  end

  // ==========================================================
  // Answers, one cycle after the command is taken.
  // Queries answer with data, set commands answer only when refused.
  // A refused query drives zero data so stale values never leak.
  reg [15:0] rd_d;
  reg        err_d;
  reg        rsp_d;
  reg [15:0] ev_sel;
  reg [15:0] cd_sel;
  reg [15:0] mk_sel;
  integer    i;

  // Pick the addressed module's words; an index out of range reads zero.
  // The loop is plain muxing, one comparator per module.
  always @* begin
    ev_sel = 16'h0000;
    cd_sel = 16'h0000;
    mk_sel = 16'h0000;
    for (i = 0; i < N_MOD; i = i + 1) begin
      if (cmd_mod_in == i[3:0]) begin
        ev_sel = ch_evt_q[i];
        cd_sel = ch_cond[i];
        mk_sel = ch_mask_q[i];
      end
    end
  end

  // Decode the answer and the refusal for the command on the bus.
  // Every path assigns all three so no latch is inferred.
  always @* begin
    rd_d  = 16'h0000;
    err_d = 1'b0;
    rsp_d = 1'b1;
    case (cmd_code_in)
      `LPSR_HV_LIM_QRY:  rd_d[VW-1:0] = hv_lim_out;
      `LPSR_LV_LIM_QRY:  rd_d[VW-1:0] = lv_lim_out;
      `LPSR_HV_ERR_QRY:  rd_d = {15'h0000, hv_err_out};
      `LPSR_LV_ERR_QRY:  rd_d = {15'h0000, lv_err_out};
      `LPSR_PULSE_QRY: begin
        case (cmd_arg_in[1:0])
          `LPSR_PQ_LEVEL: rd_d = p_level_q;
          `LPSR_PQ_TIME:  rd_d = p_time_q;
          `LPSR_PQ_COUNT: rd_d = p_count_q;
          default:        rd_d = p_period_q;
        endcase
      end
      `LPSR_CH_EVT_QRY:  begin rd_d = ev_sel; err_d = ~mod_ok; end
      `LPSR_CH_COND_QRY: begin rd_d = cd_sel; err_d = ~mod_ok; end
      `LPSR_CH_MASK_QRY: begin rd_d = mk_sel; err_d = ~mod_ok; end
      `LPSR_SUM_EVT_QRY:  rd_d = sum_event_out;
      `LPSR_SUM_MASK_QRY: rd_d = sum_mask_q;
      `LPSR_OP_EVT_QRY:   rd_d = op_evt_q;
      `LPSR_OP_MASK_QRY:  rd_d = op_mask_q;
      // Only argument 0 is meaningful for the clearing commands.
      `LPSR_HV_ERR_SET:   begin rsp_d = 1'b0; err_d = ~arg0; end
      `LPSR_LV_ERR_SET:   begin rsp_d = 1'b0; err_d = ~arg0; end
      `LPSR_CH_COND_SET:  begin rsp_d = 1'b0; err_d = ~(arg0 & mod_ok); end
      `LPSR_CH_MASK_SET:  begin rsp_d = 1'b0; err_d = ~mod_ok; end
      `LPSR_PULSE_CFG:    begin rsp_d = 1'b0; err_d = cnt_bad; end
      `LPSR_HV_LIM_SET, `LPSR_LV_LIM_SET, `LPSR_PULSE_START,
      `LPSR_SUM_MASK_SET, `LPSR_OP_MASK_SET: rsp_d = 1'b0;
      default:            begin rsp_d = 1'b0; err_d = 1'b1; end
    endcase
  end

  // Answer strobes are registered so every output leaves a flip-flop.
  // The period flag rides along with any pulse query answer.
  always @(posedge clk_in) begin
    if (srst_in) begin
      rsp_valid_out   <= 1'b0;
      rsp_err_out     <= 1'b0;
      rsp_data_out    <= 16'h0000;
      rsp_has_per_out <= 1'b0;
    end else if (ce_in) begin
      rsp_valid_out   <= go & rsp_d & ~err_d;
      rsp_err_out     <= go & err_d;
      rsp_data_out    <= (go & rsp_d & ~err_d) ? rd_d : 16'h0000;
      rsp_has_per_out <= go & (cmd_code_in == `LPSR_PULSE_QRY) & p_has_per_q;
    end
  end

endmodule // lpsr_top

// ==== sim/lpsr_top_properties.sv ====
// Port-level assertions for the load status block.
`timescale 1ns/1ns
`include "lpsr_defs.vh"
module lpsr_props #(
  parameter VW = 16  // Voltage width.
) (
  input wire          clk_in,          // Clock.
  input wire          srst_in,         // Reset.
  input wire          ce_in,           // Enable.
  input wire          cmd_valid_in,    // Strobe.
  input wire [4:0]    cmd_code_in,     // Code.
  input wire [15:0]   cmd_arg_in,      // Argument.
  input wire [VW-1:0] meas_v_in,       // Voltage.
  input wire          meas_ok_in,      // Voltage valid.
  input wire          rsp_valid_out,   // Answer strobe.
  input wire [15:0]   rsp_data_out,    // Answer.
  input wire [VW-1:0] hv_lim_out,      // High limit.
  input wire [VW-1:0] lv_lim_out,      // Low limit.
  input wire          hv_err_out,      // High flag.
  input wire          lv_err_out,      // Low flag.
  input wire          pulse_start_out, // Launch.
  input wire          nv_wr_out        // Store strobe.
);
  // Flags are judged against the limits in force, commands only when taken.
  wire tk = ce_in && cmd_valid_in;
  wire hi = meas_ok_in && meas_v_in > hv_lim_out;
  wire lo = meas_ok_in && meas_v_in < lv_lim_out;
  wire st = tk && cmd_code_in == `LPSR_PULSE_START;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ==========================================================
  // Flags, answers, launches and stores
  chk_hv_trip: assert property (ce_in && hi |=> hv_err_out)
    else $error("high flag missed a trip");
  chk_lv_trip: assert property (ce_in && lo |=> lv_err_out)
    else $error("low flag missed a trip");
  chk_hv_clear: assert property (tk && cmd_code_in == `LPSR_HV_ERR_SET && !hi
    && cmd_arg_in == 16'h0000 |=> !hv_err_out) else $error("high flag not cleared");
  chk_lv_hold: assert property (lv_err_out && !(tk && cmd_code_in == `LPSR_LV_ERR_SET)
    |=> lv_err_out) else $error("low flag dropped");
  chk_flag_answer: assert property (tk && (cmd_code_in == `LPSR_HV_ERR_QRY
    || cmd_code_in == `LPSR_LV_ERR_QRY) |=> rsp_valid_out && rsp_data_out[15:1] == 15'h0000)
    else $error("flag answer malformed");
  chk_start_pulse: assert property (st |=> pulse_start_out)
    else $error("launch missing");
  chk_no_start: assert property (ce_in && !st |=> !pulse_start_out)
    else $error("launch without command");
  chk_limit_store: assert property (tk && cmd_code_in == `LPSR_HV_LIM_SET
    |=> nv_wr_out && hv_lim_out == $past(cmd_arg_in)) else $error("limit not stored");
endmodule // lpsr_props

bind lpsr_top lpsr_props #(.VW(VW)) u_props (
  .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid_in),
  .cmd_code_in(cmd_code_in), .cmd_arg_in(cmd_arg_in), .meas_v_in(meas_v_in),
  .meas_ok_in(meas_ok_in), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
  .hv_lim_out(hv_lim_out), .lv_lim_out(lv_lim_out), .hv_err_out(hv_err_out),
  .lv_err_out(lv_err_out), .pulse_start_out(pulse_start_out), .nv_wr_out(nv_wr_out));

// ==== sim/lpsr_host.sv ====
// Host controller model that issues commands and collects answers.
`timescale 1ns/1ns
module lpsr_host (
  input  wire        clk_in,                   // Clock.
  input  wire        rsp_valid_in,             // Answer strobe.
  input  wire [15:0] rsp_data_in,              // Answer.
  input  wire        rsp_err_in,               // Refusal.
  output reg         cmd_valid_out = 1'b0,     // Strobe.
  output reg  [4:0]  cmd_code_out = 5'h00,     // Code.
  output reg  [3:0]  cmd_mod_out = 4'h0,       // Module.
  output reg  [15:0] cmd_arg_out = 16'h0000,   // Argument.
  output reg  [15:0] cmd_time_out = 16'h0000,  // Duration.
  output reg  [15:0] cmd_period_out = 16'h0000, // Period.
  output reg  [15:0] cmd_count_out = 16'h0000, // Count.
  output reg         cmd_has_per_out = 1'b0,   // Period given.
  output reg         cmd_has_cnt_out = 1'b0    // Count given.
);
  // One command, held for the edge that takes it; the answer is read after that edge.
  // Callers keep duration and period legal, the device does not check them.
  task send(input [4:0] c, input [3:0] m, input [15:0] a, input [49:0] px,
            output [15:0] d, output v, output e);
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_code_out = c;
    cmd_mod_out = m;
    cmd_arg_out = a;
    {cmd_has_per_out, cmd_has_cnt_out, cmd_count_out, cmd_period_out, cmd_time_out} = px;
    @(posedge clk_in);
    #1;
    d = rsp_data_in;
    v = rsp_valid_in;
    e = rsp_err_in;
    cmd_valid_out = 1'b0;
    // A released argument changes, so a stale value never passes for a live one.
    cmd_arg_out = ~a;
  endtask
endmodule // lpsr_host

// ==== sim/tb_lpsr_top.sv ====
// Self-checking bench for the load status block.
`timescale 1ns/1ns
`include "lpsr_defs.vh"
module tb_lpsr_top;
  reg          clk_in = 1'b0;
  reg          srst_in = 1'b1;
  reg  [15:0]  nv_hv = 16'hc000;
  reg  [15:0]  meas = 16'h0000;
  reg          m_ok = 1'b0;
  reg          ce = 1'b1;
  reg  [239:0] cond = 240'h0;
  reg  [15:0]  opev = 16'h0000;
  reg  [31:0]  rs = 32'h531d;
  reg  [15:0]  d;
  reg          v, e;
  reg  [15:0]  pq [0:3];
  integer      n_errors = 0;
  integer      checks_done = 0;
  integer      he = 0;
  integer      le = 0;
  integer      i;
  wire         cv, hp, hc, rv, re, rh, nw, ns, hf, lf, lp, os;
  wire [4:0]   cc;
  wire [3:0]   cm;
  wire [15:0]  ca, ct, cp, cn, rd, nd, hl, ll, se;
  // Free-running 50 MHz clock.
  always #10 clk_in = ~clk_in;
  lpsr_host h (.clk_in(clk_in), .rsp_valid_in(rv), .rsp_data_in(rd), .rsp_err_in(re),
    .cmd_valid_out(cv), .cmd_code_out(cc), .cmd_mod_out(cm), .cmd_arg_out(ca),
    .cmd_time_out(ct), .cmd_period_out(cp), .cmd_count_out(cn), .cmd_has_per_out(hp),
    .cmd_has_cnt_out(hc));
  lpsr_top dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .cmd_valid_in(cv),
    .cmd_code_in(cc), .cmd_mod_in(cm), .cmd_arg_in(ca), .cmd_time_in(ct), .cmd_period_in(cp),
    .cmd_count_in(cn), .cmd_has_per_in(hp), .cmd_has_cnt_in(hc), .nv_hv_lim_in(nv_hv),
    .nv_lv_lim_in(16'h2000), .meas_v_in(meas), .meas_ok_in(m_ok), .mod_cond_in(cond),
    .op_evt_in(opev), .rsp_valid_out(rv), .rsp_data_out(rd), .rsp_err_out(re),
    .rsp_has_per_out(rh), .nv_wr_out(nw), .nv_sel_out(ns), .nv_data_out(nd), .hv_lim_out(hl),
    .lv_lim_out(ll), .hv_err_out(hf), .lv_err_out(lf), .pulse_start_out(lp),
    .op_summary_out(os), .sum_event_out(se));
  // ==========================================================
  // Helpers
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task ck(input ok, input string m);
    checks_done = checks_done + 1;
    if (ok !== 1'b1) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task q(input [4:0] c, input [3:0] m, input [15:0] a, input [15:0] x);
    h.send(c, m, a, 50'h0, d, v, e);
    ck(v === 1'b1 && d === x, "query answer");
  endtask
  task s(input [4:0] c, input [3:0] m, input [15:0] a, input [49:0] px, input r);
    h.send(c, m, a, px, d, v, e);
    ck(v === 1'b0 && e === r, "set outcome");
  endtask
  task tick;
    @(posedge clk_in);
    #1;
  endtask
  // Reset is held three edges; the limits reload from the stored values.
  task rst;
    srst_in = 1'b1;
    repeat (3) tick;
    srst_in = 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    rst;
    q(`LPSR_HV_LIM_QRY, 4'h0, 16'h0000, 16'hc000);
    q(`LPSR_LV_LIM_QRY, 4'h0, 16'h0000, 16'h2000);
    q(`LPSR_PULSE_QRY, 4'h0, 16'h0002, 16'h0001);
    // Random voltages; the model flags latch as the device's must.
    repeat (64) begin
      rs = xs(rs);
      meas = rs[15:0];
      m_ok = rs[20];
      tick;
      if (m_ok && meas > nv_hv) he = 1;
      if (m_ok && meas < 16'h2000) le = 1;
      ck(hf === he[0] && lf === le[0], "error flags");
    end
    m_ok = 1'b0;
    s(`LPSR_HV_ERR_SET, 4'h0, 16'h0001, 50'h0, 1'b1);
    q(`LPSR_HV_ERR_QRY, 4'h0, 16'h0000, {15'h0000, he[0]});
    s(`LPSR_HV_ERR_SET, 4'h0, 16'h0000, 50'h0, 1'b0);
    s(`LPSR_LV_ERR_SET, 4'h0, 16'h0000, 50'h0, 1'b0);
    // Exactly at the high limit nothing trips; one step beyond either limit does.
    meas = nv_hv;
    m_ok = 1'b1;
    q(`LPSR_HV_ERR_QRY, 4'h0, 16'h0000, 16'h0000);
    meas = nv_hv + 16'h0001;
    q(`LPSR_HV_ERR_QRY, 4'h0, 16'h0000, 16'h0001);
    q(`LPSR_LV_ERR_QRY, 4'h0, 16'h0000, 16'h0000);
    meas = 16'h1fff;
    q(`LPSR_LV_ERR_QRY, 4'h0, 16'h0000, 16'h0001);
    m_ok = 1'b0;
    s(`LPSR_HV_LIM_SET, 4'h0, 16'h9abc, 50'h0, 1'b0);
    ck(nw === 1'b1 && ns === 1'b0 && nd === 16'h9abc && hl === 16'h9abc, "store");
    s(`LPSR_LV_LIM_SET, 4'h0, 16'h0456, 50'h0, 1'b0);
    ck(nw === 1'b1 && ns === 1'b1 && ll === 16'h0456, "low store");
    // Clock enable low: the command is ignored and the limit holds.
    ce = 1'b0;
    s(`LPSR_HV_LIM_SET, 4'h0, 16'h0bad, 50'h0, 1'b0);
    ce = 1'b1;
    q(`LPSR_HV_LIM_QRY, 4'h0, 16'h0000, 16'h9abc);
    // Last follower: latch, mask, summarise, then clear.
    s(`LPSR_SUM_MASK_SET, 4'h0, 16'hffff, 50'h0, 1'b0);
    q(`LPSR_SUM_MASK_QRY, 4'h0, 16'h0000, 16'h7fff);
    cond[224 +: 16] = 16'h1013;
    tick;
    cond[224 +: 16] = 16'h0000;
    q(`LPSR_CH_COND_QRY, 4'he, 16'h0000, 16'h0000);
    q(`LPSR_CH_EVT_QRY, 4'he, 16'h0000, 16'h1013);
    ck(se === 16'h0000, "unmasked summary");
    s(`LPSR_CH_MASK_SET, 4'he, 16'hffff, 50'h0, 1'b0);
    q(`LPSR_CH_MASK_QRY, 4'he, 16'h0000, 16'h301b);
    ck(se === 16'h4000, "module summary");
    q(`LPSR_SUM_EVT_QRY, 4'he, 16'h0000, 16'h4000);
    s(`LPSR_CH_COND_SET, 4'he, 16'h0001, 50'h0, 1'b1);
    s(`LPSR_CH_COND_SET, 4'he, 16'h0000, 50'h0, 1'b0);
    q(`LPSR_CH_EVT_QRY, 4'he, 16'h0000, 16'h0000);
    q(`LPSR_CH_MASK_QRY, 4'he, 16'h0000, 16'h0000);
    ck(se === 16'h0000, "summary cleared");
    s(`LPSR_CH_EVT_QRY, 4'hf, 16'h0000, 50'h0, 1'b1);
    // Pulse setup: counts out of range are refused, a good one is only stored.
    s(`LPSR_PULSE_CFG, 4'h0, 16'h0123, {2'b01, 32'h0, 16'h0040}, 1'b1);
    s(`LPSR_PULSE_CFG, 4'h0, 16'h0123, {2'b01, 16'hfde9, 32'h40}, 1'b1);
    s(`LPSR_PULSE_CFG, 4'h0, 16'h0123, {2'b01, 16'hfde8, 32'h40}, 1'b0);
    ck(lp === 1'b0, "early launch");
    pq[0] = 16'h0123;
    pq[1] = 16'h0040;
    pq[2] = 16'hfde8;
    pq[3] = 16'h0000;
    for (i = 0; i < 4; i = i + 1) begin
      q(`LPSR_PULSE_QRY, 4'h0, i[15:0], pq[i]);
    end
    ck(rh === 1'b0, "period flag set");
    s(`LPSR_PULSE_CFG, 4'h0, 16'h0123, {2'b11, 32'h00020100, 16'h0040}, 1'b0);
    q(`LPSR_PULSE_QRY, 4'h0, 16'h0003, 16'h0100);
    ck(rh === 1'b1, "period flag");
    s(`LPSR_PULSE_START, 4'h0, 16'h0000, 50'h0, 1'b0);
    ck(lp === 1'b1, "launch");
    // Operation events: read clears, masked OR drives the summary.
    opev = 16'h0090;
    tick;
    opev = 16'h0000;
    q(`LPSR_OP_EVT_QRY, 4'h0, 16'h0000, 16'h0090);
    q(`LPSR_OP_EVT_QRY, 4'h0, 16'h0000, 16'h0000);
    s(`LPSR_OP_MASK_SET, 4'h0, 16'h0010, 50'h0, 1'b0);
    q(`LPSR_OP_MASK_QRY, 4'h0, 16'h0000, 16'h0010);
    opev = 16'h0080;
    tick;
    tick;
    ck(os === 1'b0, "masked summary");
    opev = 16'h0010;
    tick;
    tick;
    ck(os === 1'b1, "op summary");
    nv_hv = 16'h1234;
    rst;
    q(`LPSR_HV_LIM_QRY, 4'h0, 16'h0000, 16'h1234);
    give_verdict;
  end
endmodule // tb_lpsr_top
